// File: rtl/hpslc_regs.svh
// Offsets, field positions and reset values of the slot and link tuning registers
`ifndef HPSLC_REGS_SVH
`define HPSLC_REGS_SVH
`define HPSLC_OFF_SLOT_FEATURES 8'hC4
`define HPSLC_OFF_SLOT_CTL 8'hC8
`define HPSLC_OFF_PHY_TUNE0 8'hCC
`define HPSLC_OFF_PHY_TUNE1 8'hD0
`define HPSLC_OFF_EVT_CLEAR 8'hE0
`define HPSLC_OFF_IRQ_ENABLE 8'hE4
`define HPSLC_CAP_MASK 32'h0000005D
`define HPSLC_CTL_W 11
`define HPSLC_CTL_RST 11'h000
`define HPSLC_EVT_W 5
`define HPSLC_EVT_LSB 16
`define HPSLC_MRL_STATE_BIT 21
`define HPSLC_PRES_STATE_BIT 22
`define HPSLC_CTL_MASTER_BIT 5
`define HPSLC_PHY0_LO_W 13
`define HPSLC_PHY0_LO_RST 13'h1060
`define HPSLC_PHY0_HI_RST 16'h0400
`define HPSLC_PHY1_LO_W 10
`define HPSLC_PHY1_LO_RST 10'h000
`define HPSLC_PHY1_HI_RST 16'h0000
`endif

// File: rtl/hpslc_pkg.sv
// Types shared by the slot and link tuning register bank
package hpslc_pkg;
   typedef logic [7:0] hpslc_addr_t;
   typedef logic [31:0] hpslc_word_t;
   typedef logic [4:0] hpslc_evt_t;
endpackage

// File: rtl/hotplug_slot_link_cfg_regs.sv
// Hot-plug slot capability, control, status and link tuning registers
// Behaviour
// - Presence bits 0,2,3,4,6 read one with hot-plug strapped in reverse mode, else zero.
// - Those presence bits take their value from the strap at reset.
// - Power limit, scale and physical slot number fields read constant zero.
// - Slot event enables, bits 0 to 4, read-write, cleared at reset.
// - Master interrupt enable bit 5, indicator fields and power control, cleared at reset.
// - Hot reset, loopback, crosslink enables bits 0 to 2, cleared at reset.
// - Bit 3 sends the link state machine to Configuration; resets to zero.
// - Bit 4 selects internal debug mode; resets to zero.
// - Lane negotiation tries 7:5 reset 3h; TS1 count 12:8 reset 10h.
// - L1-entry timer default bits 31:16 read-write, reset 0400h.
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`include "hpslc_regs.svh"
module hotplug_slot_link_cfg_regs (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register port
   input wire hpslc_pkg::hpslc_addr_t regAddr,
   input wire hpslc_pkg::hpslc_word_t regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output hpslc_pkg::hpslc_word_t regRdData,
   // Straps
   input wire logic hotPlugStrap,
   input wire logic reverseMode,
   // Slot events and states from the hot-plug controller
   input wire hpslc_pkg::hpslc_evt_t slotEvt,
   input wire logic mrlState,
   input wire logic presenceState,
   // Slot controls
   output logic [1:0] attnIndCtl,
   output logic [1:0] pwrIndCtl,
   output logic pwrCtlCtl,
   output logic hotPlugIrq,
   // Link tuning controls
   output logic hotResetEn,
   output logic loopbackEn,
   output logic crosslinkEn,
   output logic swDirectCfg,
   output logic debugSel,
   output logic [2:0] laneNegTries,
   output logic [4:0] ts1Count,
   output logic [15:0] l1EnterTimer,
   output logic [9:0] l0sLifetime,
   output logic [15:0] l1Lifetime
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   // Shared write decode
   function automatic logic wrHit(input hpslc_pkg::hpslc_addr_t a,
                                  input hpslc_pkg::hpslc_addr_t off);
      wrHit = regWrEn && (a == off);
   endfunction

   logic hpCapReg;
   logic [`HPSLC_CTL_W-1:0] slotCtlReg;
   hpslc_pkg::hpslc_evt_t evtReg;
   hpslc_pkg::hpslc_evt_t evtNext;
   hpslc_pkg::hpslc_evt_t irqEnReg;
   logic mrlStateReg;
   logic presStateReg;
   logic [`HPSLC_PHY0_LO_W-1:0] phy0LoReg;
   logic [15:0] phy0HiReg;
   logic [`HPSLC_PHY1_LO_W-1:0] phy1LoReg;
   logic [15:0] phy1HiReg;
   hpslc_pkg::hpslc_word_t capWord;
   hpslc_pkg::hpslc_word_t rdNext;
   hpslc_pkg::hpslc_evt_t evtClr;

   ////////////////////////////////////////////////////////////////////////////
   // Strap capture

   // Caught while reset is held so the presence bits follow the strap
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hpCapReg <= hotPlugStrap & reverseMode;
      end
   end

   // Strap-dependent bits only; power limit and slot number stay zero
   assign capWord = hpCapReg ? `HPSLC_CAP_MASK : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////
   // Slot control

   // Enables, indicators and power control, zero after reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         slotCtlReg <= `HPSLC_CTL_RST;
      end else if (wrHit(regAddr, `HPSLC_OFF_SLOT_CTL)) begin
         slotCtlReg <= regWrData[`HPSLC_CTL_W-1:0];
      end
   end

   assign attnIndCtl = slotCtlReg[7:6];
   assign pwrIndCtl = slotCtlReg[9:8];
   assign pwrCtlCtl = slotCtlReg[10];

   ////////////////////////////////////////////////////////////////////////////
   // Slot status and interrupt

   // Clear pulses only on writes to the clear register
   assign evtClr = wrHit(regAddr, `HPSLC_OFF_EVT_CLEAR) ?
                   regWrData[`HPSLC_EVT_W-1:0] : 5'h00;

   // Sticky event bits; an event in the clearing cycle survives
   genvar gi;
   generate
      for (gi = 0; gi < `HPSLC_EVT_W; gi++) begin : g_evt
         assign evtNext[gi] = slotEvt[gi] | (evtReg[gi] & ~evtClr[gi]);
      end
   endgenerate

   // Status is not software-writable at its own offset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         evtReg <= 5'h00;
         mrlStateReg <= 1'b0;
         presStateReg <= 1'b0;
      end else begin
         evtReg <= evtNext;
         mrlStateReg <= mrlState;
         presStateReg <= presenceState;
      end
   end

   // Interrupt enable register, same layout as the events
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irqEnReg <= 5'h00;
      end else if (wrHit(regAddr, `HPSLC_OFF_IRQ_ENABLE)) begin
         irqEnReg <= regWrData[`HPSLC_EVT_W-1:0];
      end
   end

   // Gated by the slot enables and the master enable as well
   assign hotPlugIrq = slotCtlReg[`HPSLC_CTL_MASTER_BIT] &
                       (|(evtReg & irqEnReg & slotCtlReg[`HPSLC_EVT_W-1:0]));

   ////////////////////////////////////////////////////////////////////////////
   // Link tuning registers

   // Tuning word 0
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         phy0LoReg <= `HPSLC_PHY0_LO_RST;
         phy0HiReg <= `HPSLC_PHY0_HI_RST;
      end else if (wrHit(regAddr, `HPSLC_OFF_PHY_TUNE0)) begin
         phy0LoReg <= regWrData[`HPSLC_PHY0_LO_W-1:0];
         phy0HiReg <= regWrData[31:16];
      end
   end

   // Tuning word 1
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         phy1LoReg <= `HPSLC_PHY1_LO_RST;
         phy1HiReg <= `HPSLC_PHY1_HI_RST;
      end else if (wrHit(regAddr, `HPSLC_OFF_PHY_TUNE1)) begin
         phy1LoReg <= regWrData[`HPSLC_PHY1_LO_W-1:0];
         phy1HiReg <= regWrData[31:16];
      end
   end

   assign hotResetEn = phy0LoReg[0];
   assign loopbackEn = phy0LoReg[1];
   assign crosslinkEn = phy0LoReg[2];
   assign swDirectCfg = phy0LoReg[3];
   assign debugSel = phy0LoReg[4];
   assign laneNegTries = phy0LoReg[7:5];
   assign ts1Count = phy0LoReg[12:8];
   assign l1EnterTimer = phy0HiReg;
   assign l0sLifetime = phy1LoReg;
   assign l1Lifetime = phy1HiReg;

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   // Reserved and unmapped bits read zero; the clear register reads zero
   always_comb begin
      rdNext = 32'h00000000;
      case (regAddr)
         `HPSLC_OFF_SLOT_FEATURES: rdNext = capWord;
         `HPSLC_OFF_SLOT_CTL: begin
            rdNext[`HPSLC_CTL_W-1:0] = slotCtlReg;
            rdNext[`HPSLC_EVT_LSB+4:`HPSLC_EVT_LSB] = evtReg;
            rdNext[`HPSLC_MRL_STATE_BIT] = mrlStateReg;
            rdNext[`HPSLC_PRES_STATE_BIT] = presStateReg;
         end
         `HPSLC_OFF_PHY_TUNE0: rdNext = {phy0HiReg, 3'h0, phy0LoReg};
         `HPSLC_OFF_PHY_TUNE1: rdNext = {phy1HiReg, 6'h00, phy1LoReg};
         `HPSLC_OFF_IRQ_ENABLE: rdNext[`HPSLC_EVT_W-1:0] = irqEnReg;
         default: rdNext = 32'h00000000;
      endcase
   end

   // Data stands only in the cycle after the read strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         regRdData <= 32'h00000000;
      end else if (regRdEn) begin
         regRdData <= rdNext;
      end else begin
         regRdData <= 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   // Properties test the strobes directly; a function body would see post-edge values
   sequence sRdCap;
      regRdEn && (regAddr == `HPSLC_OFF_SLOT_FEATURES);
   endsequence

   sequence sRdPhy;
      regRdEn && (regAddr == `HPSLC_OFF_PHY_TUNE0 || regAddr == `HPSLC_OFF_PHY_TUNE1);
   endsequence

   sequence sWrCtl;
      regWrEn && (regAddr == `HPSLC_OFF_SLOT_CTL);
   endsequence

   chk_cap_strap_follow: assert property (@(posedge ref_clk)
      $fell(rst) |-> (capWord[6] == $past(hotPlugStrap & reverseMode)) &&
         (capWord[4:2] == {3{capWord[6]}}) && (capWord[0] == capWord[6]))
      else $error("presence bits do not follow strap");

   chk_cap_zero_fields: assert property (@(posedge ref_clk) disable iff (rst)
      sRdCap |=> (regRdData[31:7] == 25'h0000000) && !regRdData[5] && !regRdData[1])
      else $error("constant slot fields not zero");

   chk_ctl_write_hold: assert property (@(posedge ref_clk) disable iff (rst)
      sWrCtl ##1 (!regWrEn)[*2] |-> slotCtlReg == $past(regWrData[10:0], 2))
      else $error("slot control did not keep written value");

   chk_ctl_reset_zero: assert property (@(posedge ref_clk)
      rst |=> (slotCtlReg == 11'h000) && !hotPlugIrq)
      else $error("slot control not cleared by reset");

   chk_phy_reset_vals: assert property (@(posedge ref_clk)
      rst |=> (laneNegTries == 3'h3) && (ts1Count == 5'h10) &&
         (l1EnterTimer == 16'h0400) && (phy0LoReg[4:0] == 5'h00))
      else $error("tuning word 0 reset values wrong");

   chk_phy_write_read: assert property (@(posedge ref_clk) disable iff (rst)
      regWrEn && (regAddr == `HPSLC_OFF_PHY_TUNE0) ##1 (regRdEn &&
         regAddr == `HPSLC_OFF_PHY_TUNE0 && !regWrEn) |=>
         regRdData[31:16] == $past(regWrData[31:16], 2))
      else $error("timer default readback mismatch");

   chk_rsvd_read_zero: assert property (@(posedge ref_clk) disable iff (rst)
      sRdPhy |=> (regRdData[15:13] == 3'h0) && (regRdData[15:10] == 6'h00 ||
         $past(regAddr) == `HPSLC_OFF_PHY_TUNE0))
      else $error("reserved tuning bits not zero");

   chk_event_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
      slotEvt[0] |=> evtReg[0])
      else $error("event lost against clear");

   chk_irq_gate_level: assert property (@(posedge ref_clk) disable iff (rst)
      (!slotCtlReg[5]) |-> !hotPlugIrq)
      else $error("interrupt without master enable");

   // Event 0 arriving with every gate open and no register write in flight
   sequence sEvt0Armed;
      slotEvt[0] && !regWrEn && slotCtlReg[`HPSLC_CTL_MASTER_BIT] &&
         slotCtlReg[0] && irqEnReg[0];
   endsequence

   sequence sClrEvt0;
      regWrEn && (regAddr == `HPSLC_OFF_EVT_CLEAR) && regWrData[0] && !slotEvt[0];
   endsequence

   sequence sWrStatusOff;
      regWrEn && (regAddr == `HPSLC_OFF_SLOT_CTL) && (slotEvt == 5'h00);
   endsequence

   chk_irq_event_raise: assert property (@(posedge ref_clk) disable iff (rst)
      sEvt0Armed |=> hotPlugIrq)
      else $error("enabled event did not raise interrupt");

   chk_evt_clear_drop: assert property (@(posedge ref_clk) disable iff (rst)
      sClrEvt0 |=> !evtReg[0])
      else $error("event bit not cleared");

   chk_status_write_ignored: assert property (@(posedge ref_clk) disable iff (rst)
      sWrStatusOff |=> evtReg == $past(evtReg))
      else $error("status bits changed by control write");

   chk_rdata_idle_zero: assert property (@(posedge ref_clk) disable iff (rst)
      !regRdEn |=> regRdData == 32'h00000000)
      else $error("read data outside read cycle");

   chk_cap_held_const: assert property (@(posedge ref_clk) disable iff (rst)
      !rst |=> $stable(capWord))
      else $error("presence bits changed outside reset");

   chk_phy1_write_take: assert property (@(posedge ref_clk) disable iff (rst)
      regWrEn && (regAddr == `HPSLC_OFF_PHY_TUNE1) |=>
         {l1Lifetime, l0sLifetime} == {$past(regWrData[31:16]), $past(regWrData[9:0])})
      else $error("tuning word 1 write not taken");

endmodule

// File: verif/tb_top.sv
// Self-checking bench for the slot and link tuning register bank
`timescale 1ns/10ps
`include "hpslc_regs.svh"
`define CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin nMismatch++; \
   $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
   ////////////////////////////////////////////////////////////////////////////////
   // Stimulus, observed outputs and bookkeeping
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   hpslc_pkg::hpslc_addr_t regAddr = 8'h00;
   hpslc_pkg::hpslc_word_t regWrData = 32'h0;
   hpslc_pkg::hpslc_word_t regRdData;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic hotPlugStrap = 1'b0;
   logic reverseMode = 1'b0;
   hpslc_pkg::hpslc_evt_t slotEvt = 5'h00;
   logic mrlState = 1'b0;
   logic presenceState = 1'b0;
   logic [1:0] attnIndCtl, pwrIndCtl;
   logic pwrCtlCtl, hotPlugIrq, hotResetEn, loopbackEn, crosslinkEn, swDirectCfg, debugSel;
   logic [2:0] laneNegTries;
   logic [4:0] ts1Count;
   logic [15:0] l1EnterTimer, l1Lifetime;
   logic [9:0] l0sLifetime;
   int nMismatch = 0;
   int numChecks = 0;
   int cycles = 0;
   logic rdPend = 1'b0;
   hpslc_pkg::hpslc_word_t expQ[$];
   hpslc_pkg::hpslc_word_t expW;
   hpslc_pkg::hpslc_word_t d;

   // Output groups laid out as their register fields
   wire [4:0] slotOut = {pwrCtlCtl, pwrIndCtl, attnIndCtl};
   wire [28:0] tuneOut = {l1EnterTimer, ts1Count, laneNegTries, debugSel, swDirectCfg,
      crosslinkEn, loopbackEn, hotResetEn};
   wire [25:0] lifeOut = {l1Lifetime, l0sLifetime};

   // 250 MHz clock
   always #2 ref_clk = ~ref_clk;

   hotplug_slot_link_cfg_regs dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .hotPlugStrap(hotPlugStrap), .reverseMode(reverseMode), .slotEvt(slotEvt),
      .mrlState(mrlState), .presenceState(presenceState), .attnIndCtl(attnIndCtl),
      .pwrIndCtl(pwrIndCtl), .pwrCtlCtl(pwrCtlCtl), .hotPlugIrq(hotPlugIrq),
      .hotResetEn(hotResetEn), .loopbackEn(loopbackEn), .crosslinkEn(crosslinkEn),
      .swDirectCfg(swDirectCfg), .debugSel(debugSel), .laneNegTries(laneNegTries),
      .ts1Count(ts1Count), .l1EnterTimer(l1EnterTimer), .l0sLifetime(l0sLifetime),
      .l1Lifetime(l1Lifetime));

   ////////////////////////////////////////////////////////////////////////////////
   // Read answers stand one cycle only, so each is matched in that cycle
   always @(posedge ref_clk) begin
      if (rdPend) begin
         expW = expQ.pop_front();
         `CHK(regRdData, expW)
      end else if (!rst) begin
         `CHK(regRdData, 32'h0)
      end
      rdPend <= regRdEn;
   end

   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         nMismatch++;
         $display("mismatch at %0t: timeout", $time);
         endOfTest();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus cycles; each task drives right after an edge and leaves strobes to the next
   task automatic wr(input hpslc_pkg::hpslc_addr_t a, input hpslc_pkg::hpslc_word_t w);
      @(posedge ref_clk);
      regWrEn <= 1'b1;
      regRdEn <= 1'b0;
      regAddr <= a;
      regWrData <= w;
   endtask

   task automatic rd(input hpslc_pkg::hpslc_addr_t a, input hpslc_pkg::hpslc_word_t e);
      @(posedge ref_clk);
      regRdEn <= 1'b1;
      regWrEn <= 1'b0;
      regAddr <= a;
      expQ.push_back(e);
   endtask

   // Idle cycle that also sets the event pulses
   task automatic idle(input hpslc_pkg::hpslc_evt_t m);
      @(posedge ref_clk);
      regWrEn <= 1'b0;
      regRdEn <= 1'b0;
      slotEvt <= m;
   endtask

   task automatic doReset(input logic [1:0] s);
      @(posedge ref_clk);
      rst <= 1'b1;
      hotPlugStrap <= s[1];
      reverseMode <= s[0];
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
   endtask

   task automatic endOfTest();
      $display("checks %0d mismatches %0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'h556B0E0A));
      // Reset values under every strap pair; the last pair leaves hot-plug on
      for (int s = 0; s < 4; s++) begin
         doReset(2'(s));
         rd(8'hC4, (s == 3) ? 32'h0000005D : 32'h0);
         rd(8'hC8, 32'h0);
         rd(8'hCC, 32'h04001060);
         rd(8'hD0, 32'h0);
         rd(`HPSLC_OFF_IRQ_ENABLE, 32'h0);
         idle(5'h00);
         @(negedge ref_clk);
         `CHK({slotOut, hotPlugIrq}, 6'h00)
         `CHK(tuneOut, {16'h0400, 13'h1060})
         `CHK(lifeOut, 26'h0)
      end
      // All-ones then random words, read back at once; reserved bits must drop
      for (int k = 0; k < 6; k++) begin
         d = (k == 0) ? 32'hFFFFFFFF : $urandom();
         wr(8'hC8, d);
         rd(8'hC8, d & 32'h000007FF);
         wr(8'hCC, d);
         rd(8'hCC, d & 32'hFFFF1FFF);
         wr(8'hD0, d);
         rd(8'hD0, d & 32'hFFFF03FF);
         wr(8'hC4, d);
         rd(8'hC4, 32'h0000005D);
         wr(`HPSLC_OFF_IRQ_ENABLE, d);
         rd(`HPSLC_OFF_IRQ_ENABLE, d & 32'h0000001F);
         rd(`HPSLC_OFF_EVT_CLEAR, 32'h0);
         rd(8'h40, 32'h0);
         idle(5'h00);
         @(negedge ref_clk);
         `CHK(slotOut, d[10:6])
         `CHK(tuneOut, {d[31:16], d[12:0]})
         `CHK(lifeOut, {d[31:16], d[9:0]})
      end
      // Each event sets its sticky bit and raises the interrupt until cleared
      wr(8'hC8, 32'h0000003F);
      wr(`HPSLC_OFF_IRQ_ENABLE, 32'h0000001F);
      for (int i = 0; i < 5; i++) begin
         idle(5'(1 << i));
         idle(5'h00);
         @(negedge ref_clk);
         `CHK(hotPlugIrq, 1'b1)
         rd(8'hC8, 32'h0000003F | (32'h1 << (16 + i)));
         wr(`HPSLC_OFF_EVT_CLEAR, 32'h1 << i);
         idle(5'h00);
         @(negedge ref_clk);
         `CHK(hotPlugIrq, 1'b0)
      end
      // Masking by the enable register, then by the master enable
      idle(5'h01);
      wr(`HPSLC_OFF_IRQ_ENABLE, 32'h0);
      idle(5'h00);
      @(negedge ref_clk);
      `CHK(hotPlugIrq, 1'b0)
      wr(`HPSLC_OFF_IRQ_ENABLE, 32'h0000001F);
      idle(5'h00);
      @(negedge ref_clk);
      `CHK(hotPlugIrq, 1'b1)
      wr(8'hC8, 32'h0000001F);
      repeat (2) idle(5'h00);
      @(negedge ref_clk);
      `CHK(hotPlugIrq, 1'b0)
      // A clear meeting a new event keeps it; slot states mirror into status
      wr(`HPSLC_OFF_EVT_CLEAR, 32'h0000001F);
      slotEvt <= 5'h01;
      mrlState <= 1'b1;
      presenceState <= 1'b1;
      idle(5'h00);
      idle(5'h00);
      rd(8'hC8, 32'h0061001F);
      repeat (3) idle(5'h00);
      endOfTest();
   end
endmodule
